// ### buck_ctrl.sv
// Digital control of a four-rail buck regulator sharing eight power stages.
// All pins and analog comparator results arrive asynchronously and are
// synchronised here; outputs steer the power stages and the fault pin.
`timescale 1ns/1ps

module buck_ctrl
   import buck_ctrl_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        stage_combo_bit0_i,
   input  wire logic        stage_combo_bit1_i,
   input  wire logic        stage_combo_bit2_i,
   input  wire logic [3:0]  rail_enable_hi_i,      // enable above 730 mV
   input  wire logic [3:0]  rail_enable_precise_i, // enable above 400 mV
   input  wire logic [3:0]  rail_feedback_low_i,   // below falling good level
   input  wire logic [3:0]  rail_feedback_ok_i,    // above rising good level
   input  wire logic [3:0]  rail_above_target_i,   // slightly above regulation
   input  wire logic [3:0]  rail_current_zero_i,
   input  wire logic        sync_mode_i,
   input  wire logic        freq_set_input_i,      // high when tied to bias
   input  wire logic        overtemp_hot_i,        // die at the trip level
   input  wire logic        overtemp_cool_i,       // die below the release level
   input  wire logic        undervoltage_i,
   output logic [3:0][7:0]  rail_stages_o,
   output logic [3:0]       rail_run_o,
   output logic [3:0]       rail_low_side_o,
   output logic [3:0]       rail_hiz_o,
   output logic [3:0]       rail_sleep_o,
   output logic [3:0][1:0]  rail_phase_o,
   output logic             thr_precise_o,
   output logic             forced_cont_o,
   output logic             sync_lock_o,
   output logic             int_osc_o,
   output logic             overtemp_shutdown_o,
   output logic             all_rails_good_n_o,
   output logic             all_rails_good_n_oe_o
);
   function automatic logic [7:0] stage_mask(input logic [2:0] code, input int rail);
      logic [3:0][7:0] m;
      m = '0;
      case (code)
         3'h0:    m = {ST_GH,   ST_EF,   ST_CD,   ST_AB};
         3'h1:    m = {ST_GH,   ST_EF,   ST_D,    ST_ABC};
         3'h2:    m = {ST_FGH,  ST_E,    ST_D,    ST_ABC};
         3'h3:    m = {ST_FG,   ST_E,    ST_D,    ST_ABCH};
         3'h4:    m = {ST_FGH,  ST_NONE, ST_DE,   ST_ABC};
         3'h5:    m = {ST_GH,   ST_EF,   ST_NONE, ST_ABCD};
         3'h6:    m = {ST_FGH,  ST_E,    ST_NONE, ST_ABCD};
         default: m = {ST_EFGH, ST_NONE, ST_NONE, ST_ABCD};
      endcase
      return m[rail];
   endfunction

   // Two-stage synchronisers; only the second stage is read
   localparam int SYNC_W = 32;
   logic [SYNC_W-1:0] meta_ff, sync_ff;
   logic [SYNC_W-1:0] raw_in;
   assign raw_in = {stage_combo_bit2_i, stage_combo_bit1_i, stage_combo_bit0_i,
                    rail_enable_hi_i, rail_enable_precise_i, rail_feedback_low_i,
                    rail_feedback_ok_i, rail_above_target_i, rail_current_zero_i,
                    sync_mode_i, freq_set_input_i, overtemp_hot_i, overtemp_cool_i,
                    undervoltage_i};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= raw_in;
         sync_ff <= meta_ff;
      end
   end

   logic [2:0] code_s;
   logic [3:0] en_hi_s, en_pr_s, fb_low_s, fb_ok_s, above_s, izero_s;
   logic       mode_s, fset_s, hot_s, cool_s, uv_s;
   assign {code_s, en_hi_s, en_pr_s, fb_low_s, fb_ok_s, above_s, izero_s,
           mode_s, fset_s, hot_s, cool_s, uv_s} = sync_ff;

   // Mode pin: rising edges seen recently mean an external clock
   logic       mode_d_ff, lock_ff, fcm_ff, int_osc_ff, therm_ff, thr_ff;
   logic       nxt_lock, nxt_fcm, nxt_int_osc, nxt_therm, nxt_thr;
   logic [6:0] edge_cnt_ff, nxt_edge_cnt;
   logic [3:0][7:0] stages_ff, nxt_stages;

   rail_state_type [3:0] st_ff, nxt_st;
   logic [3:0] run_ff, ls_ff, hiz_ff, sleep_ff, good_ff, nxt_sleep, nxt_good;
   logic [3:0] want, avail;
   logic       any_run, rail_fault, fault_long, pg_oe_ff, nxt_pg_oe;

   always_comb begin
      nxt_edge_cnt = edge_cnt_ff;
      nxt_lock     = lock_ff;
      if (mode_s && !mode_d_ff) begin
         nxt_edge_cnt = '0;
         nxt_lock     = 1'b1;
      end else if (edge_cnt_ff < SYNC_LIMIT) begin
         nxt_edge_cnt = edge_cnt_ff + 7'h01;
      end else begin
         nxt_lock     = 1'b0;
      end
      nxt_fcm     = nxt_lock || mode_s;
      nxt_int_osc = !nxt_lock && fset_s;
      // Hysteresis: set at the hot level, cleared only once cool again
      nxt_therm = hot_s ? 1'b1 : (cool_s ? 1'b0 : therm_ff);
      for (int r = 0; r < NUM_RAILS; r++) begin
         nxt_stages[r] = stage_mask(code_s, r);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_d_ff   <= 1'b0;
         edge_cnt_ff <= '0;
         lock_ff     <= 1'b0;
         fcm_ff      <= 1'b0;
         int_osc_ff  <= 1'b0;
         therm_ff    <= 1'b0;
         stages_ff   <= '0;
      end else begin
         mode_d_ff   <= mode_s;
         edge_cnt_ff <= nxt_edge_cnt;
         lock_ff     <= nxt_lock;
         fcm_ff      <= nxt_fcm;
         int_osc_ff  <= nxt_int_osc;
         therm_ff    <= nxt_therm;
         stages_ff   <= nxt_stages;
      end
   end

   // Rail sequencing
   always_comb begin
      any_run   = |run_ff;
      nxt_thr   = any_run;
      nxt_st    = st_ff;
      nxt_sleep = sleep_ff;
      nxt_good  = good_ff;
      for (int r = 0; r < NUM_RAILS; r++) begin
         avail[r] = |stages_ff[r];
         // The precise comparator is only trusted once any rail, this one included, runs
         want[r] = avail[r] && !therm_ff && !uv_s &&
                   (thr_ff ? en_pr_s[r] : en_hi_s[r]);
         case (st_ff[r])
            RAIL_OFF: begin
               if (want[r]) begin
                  nxt_st[r] = RAIL_RUN;
               end
            end
            RAIL_RUN: begin
               if (!want[r]) begin
                  nxt_st[r] = RAIL_DRAIN;
               end
            end
            RAIL_DRAIN: begin
               if (izero_s[r]) begin
                  nxt_st[r] = RAIL_OFF;
               end
            end
            default: nxt_st[r] = RAIL_OFF;
         endcase
         if (st_ff[r] != RAIL_RUN || fcm_ff) begin
            nxt_sleep[r] = 1'b0;
         end else if (above_s[r]) begin
            nxt_sleep[r] = 1'b1;
         end else if (fb_low_s[r] || !above_s[r]) begin
            nxt_sleep[r] = 1'b0;
         end
         if (st_ff[r] != RAIL_RUN) begin
            nxt_good[r] = 1'b1;
         end else if (fb_low_s[r]) begin
            nxt_good[r] = 1'b0;
         end else if (fb_ok_s[r]) begin
            nxt_good[r] = 1'b1;
         end
      end
      rail_fault = |(run_ff & ~good_ff);
      nxt_pg_oe  = fault_long || !any_run;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff    <= {NUM_RAILS{RAIL_OFF}};
         run_ff   <= '0;
         ls_ff    <= '0;
         hiz_ff   <= '1;
         sleep_ff <= '0;
         good_ff  <= '1;
         thr_ff   <= 1'b0;
         pg_oe_ff <= 1'b1;
      end else begin
         st_ff    <= nxt_st;
         for (int r = 0; r < NUM_RAILS; r++) begin
            run_ff[r] <= (nxt_st[r] == RAIL_RUN);
            ls_ff[r]  <= (nxt_st[r] == RAIL_DRAIN);
            hiz_ff[r] <= (nxt_st[r] == RAIL_OFF);
         end
         sleep_ff <= nxt_sleep;
         good_ff  <= nxt_good;
         thr_ff   <= nxt_thr;
         pg_oe_ff <= nxt_pg_oe;
      end
   end

   rail_fault_filter u_filter (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .fault_i      (rail_fault),
      .fault_long_o (fault_long)
   );

   assign rail_stages_o         = stages_ff;
   assign rail_run_o            = run_ff;
   assign rail_low_side_o       = ls_ff;
   assign rail_hiz_o            = hiz_ff;
   assign rail_sleep_o          = sleep_ff;
   assign rail_phase_o          = {PHASE_RAIL4, PHASE_RAIL3, PHASE_RAIL2, PHASE_RAIL1};
   assign thr_precise_o         = thr_ff;
   assign forced_cont_o         = fcm_ff;
   assign sync_lock_o           = lock_ff;
   assign int_osc_o             = int_osc_ff;
   assign overtemp_shutdown_o   = therm_ff;
   assign all_rails_good_n_o    = 1'b0;
   assign all_rails_good_n_oe_o = pg_oe_ff;

   property p_all_off_low;
      @(posedge clk_i) disable iff (rst_i)
         (run_ff == 4'h0) |=> all_rails_good_n_oe_o;
   endproperty
   a_all_off_low: assert property (p_all_off_low)
      else $error("fault pin released with all rails off");

   // One cycle only: a rail may restart right after the die has cooled
   property p_hot_stops;
      @(posedge clk_i) disable iff (rst_i)
         therm_ff |=> (run_ff == 4'h0);
   endproperty
   a_hot_stops: assert property (p_hot_stops)
      else $error("rail runs during overtemperature");

   sequence s_drain;
      rail_low_side_o[0] && !rail_hiz_o[0];
   endsequence
   property p_drain_then_hiz;
      @(posedge clk_i) disable iff (rst_i)
         $fell(rail_run_o[0]) |-> s_drain;
   endproperty
   a_drain_then_hiz: assert property (p_drain_then_hiz)
      else $error("rail stopped without low-side drain");

   property p_no_run_unused;
      @(posedge clk_i) disable iff (rst_i)
         rail_run_o[1] |-> (rail_stages_o[1] != 8'h00);
   endproperty
   a_no_run_unused: assert property (p_no_run_unused)
      else $error("unused rail is running");

   property p_map_111;
      @(posedge clk_i) disable iff (rst_i)
         (code_s == 3'h7) |=> (rail_stages_o[3] == ST_EFGH && rail_stages_o[2] == ST_NONE);
   endproperty
   a_map_111: assert property (p_map_111)
      else $error("stage map wrong for code 111");

   property p_map_011;
      @(posedge clk_i) disable iff (rst_i)
         (code_s == 3'h3) |=> (rail_stages_o[0] == ST_ABCH);
   endproperty
   a_map_011: assert property (p_map_011)
      else $error("stage map wrong for code 011");

   property p_lock_fcm;
      @(posedge clk_i) disable iff (rst_i)
         sync_lock_o |-> forced_cont_o;
   endproperty
   a_lock_fcm: assert property (p_lock_fcm)
      else $error("sync lock without forced continuous");

   property p_thr;
      @(posedge clk_i) disable iff (rst_i)
         (rail_run_o != 4'h0) |=> thr_precise_o;
   endproperty
   a_thr: assert property (p_thr)
      else $error("threshold not precise with a rail running");
endmodule // buck_ctrl

// ### rail_fault_filter.sv
// Shared constants of the buck control block and the fault filter that
// turns a persisting rail fault into a combined fault level.
// Assumes one 40 MHz clock and a synchronous active-high reset.
package buck_ctrl_pkg;
   localparam int          CLK_PERIOD_NS    = 25;
   localparam int          FILTER_TIME_NS   = 100000;
   localparam int          FILTER_CYCLES    = FILTER_TIME_NS / CLK_PERIOD_NS;
   // No edge for longer than the slowest sync period means the pin is a level
   localparam int          SYNC_TIMEOUT_NS  = 2000;
   localparam int          SYNC_CYCLES      = SYNC_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int          NUM_RAILS        = 4;
   localparam int          NUM_STAGES       = 8;
   localparam logic [12:0] FILTER_LIMIT     = 13'(FILTER_CYCLES);
   localparam logic [6:0]  SYNC_LIMIT       = 7'(SYNC_CYCLES);
   // Phase offsets in quarter periods, indexed by rail number minus one
   localparam logic [1:0]  PHASE_RAIL1      = 2'h0;
   localparam logic [1:0]  PHASE_RAIL2      = 2'h1;
   localparam logic [1:0]  PHASE_RAIL3      = 2'h3;
   localparam logic [1:0]  PHASE_RAIL4      = 2'h2;
   // Stage masks, bit 0 is stage A and bit 7 is stage H
   localparam logic [7:0]  ST_NONE = 8'h00;
   localparam logic [7:0]  ST_AB   = 8'h03;
   localparam logic [7:0]  ST_ABC  = 8'h07;
   localparam logic [7:0]  ST_ABCD = 8'h0f;
   localparam logic [7:0]  ST_ABCH = 8'h87;
   localparam logic [7:0]  ST_CD   = 8'h0c;
   localparam logic [7:0]  ST_D    = 8'h08;
   localparam logic [7:0]  ST_DE   = 8'h18;
   localparam logic [7:0]  ST_E    = 8'h10;
   localparam logic [7:0]  ST_EF   = 8'h30;
   localparam logic [7:0]  ST_FG   = 8'h60;
   localparam logic [7:0]  ST_FGH  = 8'he0;
   localparam logic [7:0]  ST_GH   = 8'hc0;
   localparam logic [7:0]  ST_EFGH = 8'hf0;

   typedef enum logic [1:0] {RAIL_OFF, RAIL_RUN, RAIL_DRAIN} rail_state_type;
endpackage

`timescale 1ns/1ps

module rail_fault_filter
   import buck_ctrl_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic fault_i,
   output logic      fault_long_o
);
   logic [12:0] count_ff;
   logic [12:0] nxt_count;
   logic        fault_long_ff;
   logic        nxt_fault_long;

   always_comb begin
      // Restart whenever every running rail is good; saturate once tripped
      if (!fault_i) begin
         nxt_count = 13'h0000;
      end else if (count_ff <= FILTER_LIMIT) begin
         nxt_count = count_ff + 13'h0001;
      end else begin
         nxt_count = count_ff;
      end
      nxt_fault_long = fault_i && (count_ff > FILTER_LIMIT);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_ff      <= 13'h0000;
         fault_long_ff <= 1'b0;
      end else begin
         count_ff      <= nxt_count;
         fault_long_ff <= nxt_fault_long;
      end
   end

   assign fault_long_o = fault_long_ff;

   property p_filter_short;
      @(posedge clk_i) disable iff (rst_i)
         $rose(fault_i) |-> !fault_long_o [*8];
   endproperty
   a_filter_short: assert property (p_filter_short)
      else $error("fault passed filter too early");

   property p_filter_release;
      @(posedge clk_i) disable iff (rst_i)
         !fault_i |=> !fault_long_o;
   endproperty
   a_filter_release: assert property (p_filter_release)
      else $error("fault held after faults cleared");
endmodule // rail_fault_filter

// ### board_host_model.sv
// Board strapping, enable wiring and fault pin pull-up around the buck control.
// Assumes the bench requests enables and feedback levels; the strap code is
// only changed by the bench while the control block is held in reset.
`timescale 1ns/1ps

module board_host_model (
   input  wire logic [2:0] code_i,
   input  wire logic [3:0] en_hi_req_i,
   input  wire logic [3:0] en_pr_req_i,
   input  wire logic [3:0] fb_low_req_i,
   input  wire logic [3:0] fb_ok_req_i,
   input  wire logic       pin_data_i,
   input  wire logic       pin_oe_i,
   output logic            stage_combo_bit0_o,
   output logic            stage_combo_bit1_o,
   output logic            stage_combo_bit2_o,
   output logic [3:0]      en_hi_o,
   output logic [3:0]      en_pr_o,
   output logic [3:0]      fb_low_o,
   output logic [3:0]      fb_ok_o,
   output logic            pin_level_o
);
   logic [3:0] unused;

   // Straps are solid levels, never floating
   assign stage_combo_bit0_o = code_i[0];
   assign stage_combo_bit1_o = code_i[1];
   assign stage_combo_bit2_o = code_i[2];

   always_comb begin
      case (code_i)
         3'h4:    unused = 4'h4;
         3'h5:    unused = 4'h2;
         3'h6:    unused = 4'h2;
         3'h7:    unused = 4'h6;
         default: unused = 4'h0;
      endcase
   end

   // Unused rails get enable and feedback grounded; grounded feedback reads low
   assign en_hi_o  = en_hi_req_i & ~unused;
   assign en_pr_o  = en_pr_req_i & ~unused;
   assign fb_low_o = fb_low_req_i | unused;
   assign fb_ok_o  = fb_ok_req_i & ~unused;

   // Open-drain pin with a board pull-up
   assign pin_level_o = pin_oe_i ? pin_data_i : 1'b1;
endmodule // board_host_model

// ### testbench.sv
// Self-checking bench for the buck control block with the board model.
// Assumes one 40 MHz clock; inputs change by non-blocking assignment at edges.
`timescale 1ns/1ps

module testbench;
   import buck_ctrl_pkg::*;
   typedef struct {logic [2:0] code; logic [3:0][7:0] st;} row_type;
   logic clk_i, rst_i, sync_mode, fset, hot, cool, uv, b0, b1, b2, pin;
   logic [2:0] code;
   logic [3:0] en_hi, en_pr, fb_low, fb_ok, above, czero, en_hi_w, en_pr_w, fb_low_w, fb_ok_w;
   logic [3:0][7:0] stages;
   logic [3:0] run, lside, hiz, sleep;
   logic [3:0][1:0] phase;
   logic thr, fcont, slock, iosc, ots, gn, gn_oe;
   int error_cnt, n_compared, cycles;
   row_type rows [8];

   board_host_model board_host_model_inst (.code_i(code), .en_hi_req_i(en_hi),
      .en_pr_req_i(en_pr), .fb_low_req_i(fb_low), .fb_ok_req_i(fb_ok), .pin_data_i(gn),
      .pin_oe_i(gn_oe), .stage_combo_bit0_o(b0), .stage_combo_bit1_o(b1),
      .stage_combo_bit2_o(b2), .en_hi_o(en_hi_w), .en_pr_o(en_pr_w), .fb_low_o(fb_low_w),
      .fb_ok_o(fb_ok_w), .pin_level_o(pin));

   buck_ctrl buck_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .stage_combo_bit0_i(b0),
      .stage_combo_bit1_i(b1), .stage_combo_bit2_i(b2), .rail_enable_hi_i(en_hi_w),
      .rail_enable_precise_i(en_pr_w), .rail_feedback_low_i(fb_low_w),
      .rail_feedback_ok_i(fb_ok_w), .rail_above_target_i(above), .rail_current_zero_i(czero),
      .sync_mode_i(sync_mode), .freq_set_input_i(fset), .overtemp_hot_i(hot),
      .overtemp_cool_i(cool), .undervoltage_i(uv), .rail_stages_o(stages), .rail_run_o(run),
      .rail_low_side_o(lside), .rail_hiz_o(hiz), .rail_sleep_o(sleep), .rail_phase_o(phase),
      .thr_precise_o(thr), .forced_cont_o(fcont), .sync_lock_o(slock), .int_osc_o(iosc),
      .overtemp_shutdown_o(ots), .all_rails_good_n_o(gn), .all_rails_good_n_oe_o(gn_oe));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic summarize();
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Drives follow step; look ends at a falling edge so outputs have settled
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic look(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   // Hang guard; the whole run needs about 6500 cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         summarize();
      end
   end

   initial begin
      rows[0] = '{3'h0, {ST_GH, ST_EF, ST_CD, ST_AB}};
      rows[1] = '{3'h1, {ST_GH, ST_EF, ST_D, ST_ABC}};
      rows[2] = '{3'h2, {ST_FGH, ST_E, ST_D, ST_ABC}};
      rows[3] = '{3'h3, {ST_FG, ST_E, ST_D, ST_ABCH}};
      rows[4] = '{3'h4, {ST_FGH, ST_NONE, ST_DE, ST_ABC}};
      rows[5] = '{3'h5, {ST_GH, ST_EF, ST_NONE, ST_ABCD}};
      rows[6] = '{3'h6, {ST_FGH, ST_E, ST_NONE, ST_ABCD}};
      rows[7] = '{3'h7, {ST_EFGH, ST_NONE, ST_NONE, ST_ABCD}};
      error_cnt = 0; n_compared = 0; cycles = 0;
      rst_i = 1'b1; code = 3'h0; en_hi = 4'h0; en_pr = 4'h0; fb_low = 4'h0; fb_ok = 4'hf;
      above = 4'h0; czero = 4'h0; sync_mode = 1'b0; fset = 1'b0; hot = 1'b0; cool = 1'b1;
      uv = 1'b0;
      look(2);
      check("hiz in reset", 32'(hiz), 32'h0000000f);
      check("run in reset", 32'(run), 32'h00000000);
      check("pin low in reset", 32'(pin), 32'h00000000);
      step(2);
      rst_i <= 1'b0;
      // Strap code only changes under reset, as on a real board
      for (int i = 0; i < 8; i++) begin
         step(1);
         code <= rows[i].code;
         rst_i <= 1'b1;
         step(3);
         rst_i <= 1'b0;
         look(6);
         check("stage map", stages, rows[i].st);
         // Every stage belongs to exactly one rail, so the board can tie each group
         check("stages all used", 32'(stages[0] | stages[1] | stages[2] | stages[3]), 32'hff);
         check("stages used once", 32'($countones(stages)), 32'h8);
      end
      check("phases", 32'(phase), 32'({PHASE_RAIL4, PHASE_RAIL3, PHASE_RAIL2, PHASE_RAIL1}));
      step(1);
      code <= 3'h0;
      rst_i <= 1'b1;
      step(3);
      rst_i <= 1'b0;
      en_pr <= 4'h1;
      look(8);
      check("precise alone while all off", 32'(run), 32'h0);
      check("thr while all off", 32'(thr), 32'h0);
      step(1);
      en_hi <= 4'h1;
      look(8);
      check("rail1 runs", 32'(run), 32'h1);
      check("rail1 driven", 32'(hiz), 32'he);
      check("thr precise", 32'(thr), 32'h1);
      step(1);
      en_pr <= 4'h3;
      look(8);
      check("rail2 on precise", 32'(run), 32'h3);
      check("pin high when good", 32'(pin), 32'h1);
      step(1);
      fb_low <= 4'h2;
      fb_ok <= 4'hd;
      look(2000);
      check("short fault filtered", 32'(gn_oe), 32'h0);
      step(1);
      fb_low <= 4'h0;
      fb_ok <= 4'hf;
      look(50);
      step(1);
      fb_low <= 4'h2;
      fb_ok <= 4'hd;
      step(10);
      fb_low <= 4'h0;
      look(3975);
      check("fault not yet long", 32'(gn_oe), 32'h0);
      look(40);
      check("long fault pulls pin", 32'(pin), 32'h0);
      step(1);
      fb_ok <= 4'hf;
      look(8);
      check("pin released", 32'(gn_oe), 32'h0);
      step(1);
      en_hi <= 4'h0;
      en_pr <= 4'h2;
      look(6);
      check("rail1 stops", 32'(run), 32'h2);
      check("rail1 drains", 32'(lside[0]), 32'h1);
      check("rail1 still driven", 32'(hiz[0]), 32'h0);
      step(1);
      czero <= 4'h1;
      look(6);
      check("rail1 high-Z", 32'(hiz[0]), 32'h1);
      check("rail1 drain end", 32'(lside[0]), 32'h0);
      step(1);
      czero <= 4'h0;
      above <= 4'h2;
      look(6);
      check("rail2 sleeps", 32'(sleep), 32'h2);
      check("pulse skipping", 32'(fcont), 32'h0);
      step(1);
      sync_mode <= 1'b1;
      look(6);
      check("forced mode", 32'(fcont), 32'h1);
      check("no sleep forced", 32'(sleep), 32'h0);
      // 2 MHz sync clock: 20 cycles a period, ends low
      for (int k = 0; k < 9; k++) begin
         step(10);
         sync_mode <= ~sync_mode;
      end
      look(1);
      check("sync locked", 32'(slock), 32'h1);
      check("sync forces cont", 32'(fcont), 32'h1);
      look(120);
      check("lock lost", 32'(slock), 32'h0);
      check("level low skips", 32'(fcont), 32'h0);
      step(1);
      fset <= 1'b1;
      look(6);
      check("internal osc", 32'(iosc), 32'h1);
      step(1);
      fset <= 1'b0;
      look(6);
      check("resistor osc", 32'(iosc), 32'h0);
      step(1);
      hot <= 1'b1;
      cool <= 1'b0;
      look(6);
      check("overtemp", 32'(ots), 32'h1);
      check("overtemp stop", 32'(run), 32'h0);
      check("overtemp drain", 32'(lside[1]), 32'h1);
      step(1);
      hot <= 1'b0;
      czero <= 4'hf;
      look(6);
      check("still hot", 32'(ots), 32'h1);
      check("drained high-Z", 32'(hiz), 32'hf);
      step(1);
      cool <= 1'b1;
      czero <= 4'h0;
      en_hi <= 4'h2;
      look(8);
      check("cooled", 32'(ots), 32'h0);
      check("rail2 restarts", 32'(run), 32'h2);
      step(1);
      uv <= 1'b1;
      look(6);
      check("undervoltage stop", 32'(run), 32'h0);
      check("undervoltage drain", 32'(lside[1]), 32'h1);
      step(1);
      uv <= 1'b0;
      en_hi <= 4'h0;
      en_pr <= 4'h0;
      czero <= 4'hf;
      look(8);
      check("all off pin low", 32'(pin), 32'h0);
      summarize();
   end
endmodule // testbench
